// file: pmrc_defs.vh
`ifndef PMRC_DEFS_VH
`define PMRC_DEFS_VH

// register offsets
`define PMRC_ADDR_SOFT_RESET     8'h16
`define PMRC_ADDR_GENERAL_CONFIG 8'h17
`define PMRC_ADDR_TOP_INT_FLAGS  8'h18
`define PMRC_ADDR_CORE01_SOURCE  8'h19
`define PMRC_ADDR_CORE23_SOURCE  8'h1a
`define PMRC_ADDR_LIVE_STATUS    8'h1b

// soft_reset_control fields
`define PMRC_BIT_SOFT_RESET_CMD  0

// general_config fields and reset value
`define PMRC_BIT_SPREAD_ON       0
`define PMRC_BIT_ENABLE_ONE_PULLDOWN_SEL          1
`define PMRC_BIT_ENABLE_TWO_PULLDOWN_SEL          2
`define PMRC_BIT_WARN_SEL        3
`define PMRC_CONFIG_RESET        4'h6

// top_interrupt_flags fields
`define PMRC_BIT_LOAD_DONE       0
`define PMRC_BIT_RESET_FLAG      1
`define PMRC_BIT_WARN_FLAG       2
`define PMRC_BIT_SD_FLAG         3
`define PMRC_BIT_CORE0_PENDING   4

// per-core source layout inside a source register (ilim, sc, pg)
`define PMRC_BIT_SRC_ILIM        0
`define PMRC_BIT_SRC_SC          1
`define PMRC_BIT_SRC_PG          2
`define PMRC_SRC_UPPER_LSB       4

// live status fields
`define PMRC_BIT_WARN_LIVE       2
`define PMRC_BIT_SD_LIVE         3

// timing
`define PMRC_CLK_PERIOD_NS       8
`define PMRC_STARTUP_NS          2000

`endif

// file: pmrc_sync.v
// two-stage synchroniser for asynchronous pin levels
module pmrc_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             resetn_in,
    // async levels in, synchronised levels out
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    // first stage may go metastable; only the second stage leaves here
    reg [WIDTH-1:0] meta;
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pmrc_sync

// file: pmrc_top.v
// What this block does
// - soft reset restores defaults, reloads, resets interface
// - soft reset command bit clears itself
// - warning threshold select: 0=125C, 1=105C
// - two enable-pin pulldown selects, reset to 1
// - spread-spectrum enable bit, reset 0
// - core summary bits follow core source registers
// - shutdown temperature latches flag, disables cores
// - shutdown flag set blocks every core enable
// - warning temperature latches flag until software clears
// - reset flag on startup, undervoltage or soft reset
// - reset event: cores off, defaults, startup, then flag
// - load measurement done latches its flag
// - latched top flags clear by writing 1 or on a reset event, which reloads the sd flag from live shutdown
// - per-core pg, sc, ilim flags, write-1-clear
// - live shutdown and warning temperature status bits
`include "pmrc_defs.vh"

module pmrc_top #(
    parameter NCORE = 4
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             resetn_in,
    // register port from the serial host interface (same clock)
    input  wire [7:0]       reg_addr_in,
    input  wire [7:0]       reg_wdata_in,
    input  wire             reg_wr_in,
    input  wire             reg_rd_in,
    output reg  [7:0]       reg_rdata_out,
    output reg              host_if_reset_out,
    // asynchronous pins and analog comparators
    input  wire             hardware_reset_pin_in,
    input  wire             analog_supply_uv_in,
    input  wire             temp_over_sd_in,
    input  wire             temp_over_125_in,
    input  wire             temp_over_105_in,
    // same-clock events and requests
    input  wire [NCORE-1:0] core_en_req_in,
    input  wire [NCORE-1:0] core_pg_event_in,
    input  wire [NCORE-1:0] core_sc_event_in,
    input  wire [NCORE-1:0] core_ilim_event_in,
    input  wire             load_meas_done_in,
    // controls to the analog side
    output reg  [NCORE-1:0] core_enable_out,
    output reg              otp_reload_out,
    output reg              enable_one_pulldown_sel_out,
    output reg              enable_two_pulldown_sel_out,
    output reg              spread_spectrum_on_out,
    output reg              overtemp_warning_live_out,
    output reg              overtemp_shutdown_live_out
);
    localparam STARTUP_CYC = (`PMRC_STARTUP_NS + `PMRC_CLK_PERIOD_NS - 1)
                             / `PMRC_CLK_PERIOD_NS;
    // one-hot sequencer states
    localparam [2:0] ST_HOLD = 3'h1;
    localparam [2:0] ST_BOOT = 3'h2;
    localparam [2:0] ST_RUN  = 3'h4;

    // any-bit-set decode, used for every core summary
    function any_set;
        input [2:0] v;
        begin
            any_set = |v;
        end
    endfunction

    // reset release through two flops
    reg        rst_meta;
    reg        rst_n;
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // pins synchronised before use
    wire [4:0] pin_s;
    pmrc_sync #(.WIDTH(5)) u_sync (
        .clk_in    (clk_in),
        .resetn_in (rst_n),
        .async_in  ({temp_over_105_in, temp_over_125_in, temp_over_sd_in,
                     analog_supply_uv_in, hardware_reset_pin_in}),
        .sync_out  (pin_s)
    );
    wire hardware_reset_pin_s = pin_s[0];
    wire uv_s   = pin_s[1];
    wire sd_s   = pin_s[2];

    reg  [3:0]         config_q;
    reg  [3:0]         flags_q;
    wire [3*NCORE-1:0] src_q;
    reg  [2:0]         state;
    reg  [15:0]        boot_cnt;

    wire wr_reset  = reg_wr_in && reg_addr_in == `PMRC_ADDR_SOFT_RESET;
    wire wr_config = reg_wr_in && reg_addr_in == `PMRC_ADDR_GENERAL_CONFIG;
    wire wr_flags  = reg_wr_in && reg_addr_in == `PMRC_ADDR_TOP_INT_FLAGS;
    wire soft_rst  = wr_reset && reg_wdata_in[`PMRC_BIT_SOFT_RESET_CMD];
    wire rst_event = soft_rst | ~hardware_reset_pin_s | uv_s;
    wire warn_s    = config_q[`PMRC_BIT_WARN_SEL] ? pin_s[4] : pin_s[3];
    wire [7:0] clr = wr_flags ? reg_wdata_in : 8'h00;
    // last start-up cycle: leave boot and raise the reset flag
    wire boot_done = state == ST_BOOT &&
                     boot_cnt == STARTUP_CYC[15:0] - 16'h0001;
    // set sources of the latched flags, in register bit order
    wire [3:0] flag_set = {sd_s,
                           warn_s,
                           boot_done,
                           load_meas_done_in};

    // reset sequencer: hold while a cause lasts, then boot, then run
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_HOLD;
            boot_cnt <= 16'h0000;
        end else begin
            case (state)
                ST_HOLD: begin
                    boot_cnt <= 16'h0000;
                    if (hardware_reset_pin_s && !uv_s) begin
                        state <= ST_BOOT;
                    end
                end
                ST_BOOT: begin
                    boot_cnt <= boot_cnt + 16'h0001;
                    if (rst_event) begin
                        state <= ST_HOLD;
                    end else if (boot_done) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (rst_event) begin
                        state <= ST_HOLD;
                    end
                end
                default: state <= ST_HOLD;
            endcase
        end
    end

    // one-shot outputs: otp reload and interface reset on soft reset
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            otp_reload_out    <= 1'b1;
            host_if_reset_out <= 1'b1;
        end else begin
            otp_reload_out    <= (state == ST_HOLD) && hardware_reset_pin_s &&
                                 !uv_s;
            host_if_reset_out <= soft_rst;
        end
    end

    // configuration; the command bit is never stored so it reads 0
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= `PMRC_CONFIG_RESET;
        end else if (rst_event) begin
            config_q <= `PMRC_CONFIG_RESET;
        end else if (wr_config) begin
            config_q <= reg_wdata_in[3:0];
        end
    end

    // latched top flags: set wins over a write-1 clear
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= 4'h0;
        end else if (rst_event) begin
            flags_q <= {sd_s, 3'b000};
        end else begin
            // a 0 in the write data keeps the flag as it is
            flags_q <= flag_set | (flags_q & ~clr[3:0]);
        end
    end

    // per-core source flags, two cores per register
    genvar g;
    generate
        for (g = 0; g < NCORE; g = g + 1) begin : g_core
            wire       sel  = reg_wr_in && reg_addr_in ==
                              (g < 2 ? `PMRC_ADDR_CORE01_SOURCE
                                     : `PMRC_ADDR_CORE23_SOURCE);
            wire [2:0] wclr = sel ? reg_wdata_in[(g%2)*4 +: 3] : 3'b000;
            wire [2:0] set  = {core_pg_event_in[g], core_sc_event_in[g],
                               core_ilim_event_in[g]};
            // own register per core so each bit has a single driver
            reg  [2:0] src;
            always @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    src <= 3'b000;
                end else if (rst_event) begin
                    src <= 3'b000;
                end else begin
                    src <= set | (src & ~wclr);
                end
            end
            assign src_q[3*g +: 3] = src;
        end
    endgenerate

    // summary bits are decoded live from the source flags
    wire [NCORE-1:0] pending;
    generate
        for (g = 0; g < NCORE; g = g + 1) begin : g_sum
            assign pending[g] = any_set(src_q[3*g +: 3]);
        end
    endgenerate

    // converter enables and pin-facing controls
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            core_enable_out             <= {NCORE{1'b0}};
            enable_one_pulldown_sel_out <= 1'b1;
            enable_two_pulldown_sel_out <= 1'b1;
            spread_spectrum_on_out      <= 1'b0;
            overtemp_warning_live_out   <= 1'b0;
            overtemp_shutdown_live_out  <= 1'b0;
        end else begin
            // sd_s also gates so shutdown acts in the same cycle as latching
            if (state != ST_RUN || rst_event || sd_s ||
                flags_q[`PMRC_BIT_SD_FLAG]) begin
                core_enable_out <= {NCORE{1'b0}};
            end else begin
                core_enable_out <= core_en_req_in;
            end
            enable_one_pulldown_sel_out <=
                config_q[`PMRC_BIT_ENABLE_ONE_PULLDOWN_SEL];
            enable_two_pulldown_sel_out <=
                config_q[`PMRC_BIT_ENABLE_TWO_PULLDOWN_SEL];
            spread_spectrum_on_out      <=
                config_q[`PMRC_BIT_SPREAD_ON];
            overtemp_warning_live_out   <= warn_s;
            overtemp_shutdown_live_out  <= sd_s;
        end
    end

    // read data, one cycle after the read strobe; unmapped reads 0
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `PMRC_ADDR_SOFT_RESET:     reg_rdata_out <= 8'h00;
                `PMRC_ADDR_GENERAL_CONFIG: reg_rdata_out <= {4'h0, config_q};
                `PMRC_ADDR_TOP_INT_FLAGS:  reg_rdata_out <= {pending, flags_q};
                `PMRC_ADDR_CORE01_SOURCE:
                    reg_rdata_out <= {1'b0, src_q[5:3], 1'b0, src_q[2:0]};
                `PMRC_ADDR_CORE23_SOURCE:
                    reg_rdata_out <= {1'b0, src_q[11:9], 1'b0, src_q[8:6]};
                `PMRC_ADDR_LIVE_STATUS:
                    reg_rdata_out <= {4'h0, sd_s, warn_s, 2'b00};
                default:                   reg_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule // pmrc_top

// file: pmrc_host_model.sv
// host side of the register port: single-byte cycles, one at a time
module pmrc_host_model (
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       clk_in,
    output logic      [7:0] reg_addr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle port at time zero, no strobes before reset is released
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end
    // one-cycle write strobe; a 1 in a flag position clears it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_in);
        reg_wr_out <= 1'b0;
    endtask
    // read data lands on the strobe edge, taken just after it settles
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_in);
        reg_rd_out <= 1'b0;
        #1 d = reg_rdata_in;
    endtask
endmodule // pmrc_host_model

// file: pmrc_top_asserts.sv
`include "pmrc_defs.vh"
module pmrc_top_asserts #(
    parameter NCORE = 4
) (
    input wire             clk_in,
    input wire             resetn_in,
    input wire [7:0]       reg_addr_in,
    input wire [7:0]       reg_wdata_in,
    input wire             reg_wr_in,
    input wire             reg_rd_in,
    input wire [7:0]       reg_rdata_out,
    input wire             host_if_reset_out,
    input wire             temp_over_sd_in,
    input wire [NCORE-1:0] core_enable_out,
    input wire             otp_reload_out,
    input wire             enable_one_pulldown_sel_out,
    input wire             enable_two_pulldown_sel_out,
    input wire             spread_spectrum_on_out,
    input wire             overtemp_shutdown_live_out
);
    // decoded register requests
    wire sw = reg_wr_in && reg_addr_in == `PMRC_ADDR_SOFT_RESET
              && reg_wdata_in[`PMRC_BIT_SOFT_RESET_CMD];
    wire cfg = reg_wr_in && reg_addr_in == `PMRC_ADDR_GENERAL_CONFIG;
    wire unm = reg_addr_in < 8'h16 || reg_addr_in > 8'h1b;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_sw_if; sw |=> host_if_reset_out; endproperty
    a_sw_if: assert property (p_sw_if) else $error("if reset");
    property p_sw_otp; sw |-> ##[1:3] otp_reload_out; endproperty
    a_sw_otp: assert property (p_sw_otp) else $error("otp");
    property p_sw_off; sw |=> core_enable_out == '0; endproperty
    a_sw_off: assert property (p_sw_off) else $error("cores on");
    property p_sw_dflt; sw |=> ##1 enable_one_pulldown_sel_out
        && enable_two_pulldown_sel_out && !spread_spectrum_on_out;
    endproperty
    a_sw_dflt: assert property (p_sw_dflt) else $error("dflt");
    property p_cfg; cfg |=> ##1 {enable_two_pulldown_sel_out,
        enable_one_pulldown_sel_out, spread_spectrum_on_out}
        == $past(reg_wdata_in[2:0], 2);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config pins");
    property p_self_clr; reg_rd_in && reg_addr_in == 8'h16
        |=> reg_rdata_out == 8'h00;
    endproperty
    a_self_clr: assert property (p_self_clr) else $error("cmd");
    property p_sd_off; temp_over_sd_in |-> ##[1:6] core_enable_out == '0;
    endproperty
    a_sd_off: assert property (p_sd_off) else $error("sd");
    property p_sd_live; temp_over_sd_in [*6] |=> overtemp_shutdown_live_out;
    endproperty
    a_sd_live: assert property (p_sd_live) else $error("live");
    property p_sd_hold; overtemp_shutdown_live_out [*2]
        |-> core_enable_out == '0;
    endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("blocked");
    property p_unm; reg_rd_in && unm |=> reg_rdata_out == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped");
endmodule // pmrc_top_asserts

bind pmrc_top pmrc_top_asserts #(.NCORE(NCORE)) i_pmrc_top_asserts (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .host_if_reset_out(host_if_reset_out), .temp_over_sd_in(temp_over_sd_in),
    .core_enable_out(core_enable_out), .otp_reload_out(otp_reload_out),
    .enable_one_pulldown_sel_out(enable_one_pulldown_sel_out),
    .enable_two_pulldown_sel_out(enable_two_pulldown_sel_out),
    .spread_spectrum_on_out(spread_spectrum_on_out),
    .overtemp_shutdown_live_out(overtemp_shutdown_live_out)
);

// file: pmrc_reset_config_int_top_tb.sv
module pmrc_reset_config_int_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 1'b0, resetn_in = 1'b0, temp_sd = 1'b0;
    logic       t125 = 1'b0, t105 = 1'b0, load_done = 1'b0;
    logic       hardware_reset_pin = 1'b1, uv = 1'b0, wl, sl;
    logic [3:0] en_req = 4'h0, pg = 4'h0, sc = 4'h0, ilim = 4'h0, core_en;
    logic [7:0] addr, wdata, rdata, rd_q;
    logic       wr, rd, if_rst, otp, pd1, pd2, spr;
    int         failures = 0, n_checks = 0;
    // reset pin and undervoltage are driven to force restarts mid-run
    pmrc_top #(.NCORE(4)) i_pmrc_top (
        .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .host_if_reset_out(if_rst),
        .hardware_reset_pin_in(hardware_reset_pin), .analog_supply_uv_in(uv),
        .temp_over_sd_in(temp_sd), .temp_over_125_in(t125),
        .temp_over_105_in(t105), .core_en_req_in(en_req),
        .core_pg_event_in(pg), .core_sc_event_in(sc),
        .core_ilim_event_in(ilim), .load_meas_done_in(load_done),
        .core_enable_out(core_en), .otp_reload_out(otp),
        .enable_one_pulldown_sel_out(pd1), .enable_two_pulldown_sel_out(pd2),
        .spread_spectrum_on_out(spr), .overtemp_warning_live_out(wl),
        .overtemp_shutdown_live_out(sl));
    pmrc_host_model i_pmrc_host_model (.clk_in(clk_in), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
        .reg_rdata_in(rdata));
    // 125 MHz clock
    initial forever #4 clk_in = ~clk_in;
    // compare helpers; hold leaves us just past an edge
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic w(input logic [7:0] a, d);
        i_pmrc_host_model.wr(a, d);
    endtask
    task automatic rchk(input logic [7:0] a, e);
        i_pmrc_host_model.rd(a, rd_q);
        chk($sformatf("reg %h", a), e, rd_q);
    endtask
    // pins follow the config register one edge after it changes
    task automatic pchk(input logic [2:0] e);
        hold(1);
        chk("pins", {5'h0, e}, {5'h0, pd2, pd1, spr});
    endtask
    // defaults after power-up
    task automatic t_boot;
        rchk(8'h16, 8'h00);
        rchk(8'h17, 8'h06);
        rchk(8'h18, 8'h02);
        pchk(3'h6);
        rchk(8'h40, 8'h00);
    endtask
    // write-0 keeps, write-1 clears, load flag latches
    task automatic t_flags;
        w(8'h18, 8'h00);
        rchk(8'h18, 8'h02);
        w(8'h18, 8'h02);
        rchk(8'h18, 8'h00);
        @(posedge clk_in);
        load_done <= 1'b1;
        @(posedge clk_in);
        load_done <= 1'b0;
        rchk(8'h18, 8'h01);
        w(8'h18, 8'h01);
        rchk(8'h18, 8'h00);
    endtask
    // cores take ilim, sc, pg, ilim in turn; summary follows the source
    task automatic t_core;
        logic [7:0] src;
        for (int g = 0; g < 4; g++) begin
            src = 8'h01 << ((g % 3) + 4 * (g % 2));
            @(posedge clk_in);
            {pg[g], sc[g], ilim[g]} <= 3'h1 << (g % 3);
            @(posedge clk_in);
            {pg, sc, ilim} <= 12'h0;
            rchk(8'h18, 8'h10 << g);
            w(8'h18, 8'hf0);
            rchk(8'h18, 8'h10 << g);
            rchk(8'(8'h19 + g / 2), src);
            w(8'(8'h19 + g / 2), src);
            rchk(8'h18, 8'h00);
        end
    endtask
    // warning level select and latching beyond the live level
    task automatic t_warn;
        w(8'h17, 8'h0f);
        rchk(8'h17, 8'h0f);
        pchk(3'h7);
        @(posedge clk_in);
        t105 <= 1'b1;
        hold(6);
        rchk(8'h1b, 8'h04);
        chk("warn_live", 8'h01, {7'h0, wl});
        @(posedge clk_in);
        t105 <= 1'b0;
        hold(6);
        rchk(8'h18, 8'h04);
        w(8'h18, 8'h04);
        w(8'h17, 8'h00);
        pchk(3'h0);
        @(posedge clk_in);
        t105 <= 1'b1;
        hold(6);
        rchk(8'h18, 8'h00);
        @(posedge clk_in);
        t125 <= 1'b1;
        hold(6);
        rchk(8'h18, 8'h04);
        @(posedge clk_in);
        {t125, t105} <= 2'h0;
        hold(6);
        w(8'h18, 8'h04);
    endtask
    // shutdown drops cores and keeps them down until cleared
    task automatic t_sd;
        @(posedge clk_in);
        en_req <= 4'hf;
        hold(6);
        chk("core_en", 8'h0f, {4'h0, core_en});
        @(posedge clk_in);
        temp_sd <= 1'b1;
        hold(6);
        chk("core_en", 8'h00, {4'h0, core_en});
        chk("sd_live", 8'h01, {7'h0, sl});
        @(posedge clk_in);
        temp_sd <= 1'b0;
        hold(6);
        rchk(8'h18, 8'h08);
        chk("core_en", 8'h00, {4'h0, core_en});
        w(8'h18, 8'h08);
        hold(6);
        chk("core_en", 8'h0f, {4'h0, core_en});
    endtask
    // pin reset, then undervoltage: each forces a full restart
    task automatic t_pins;
        w(8'h17, 8'h01);
        @(posedge clk_in);
        hardware_reset_pin <= 1'b0;
        hold(6);
        chk("core_en", 8'h00, {4'h0, core_en});
        pchk(3'h6);
        @(posedge clk_in);
        hardware_reset_pin <= 1'b1;
        hold(300);
        rchk(8'h18, 8'h02);
        w(8'h18, 8'h02);
        @(posedge clk_in);
        uv <= 1'b1;
        hold(6);
        chk("core_en", 8'h00, {4'h0, core_en});
        @(posedge clk_in);
        uv <= 1'b0;
        hold(300);
        rchk(8'h18, 8'h02);
        chk("core_en", 8'h0f, {4'h0, core_en});
    endtask
    // soft reset with cores requested on and config changed
    task automatic t_swrst;
        w(8'h17, 8'h09);
        w(8'h16, 8'h01);
        #1 chk("if_rst", 8'h01, {7'h0, if_rst});
        chk("core_en", 8'h00, {4'h0, core_en});
        hold(1);
        chk("otp", 8'h01, {7'h0, otp});
        hold(300);
        rchk(8'h16, 8'h00);
        rchk(8'h17, 8'h06);
        rchk(8'h18, 8'h02);
        pchk(3'h6);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // reset for two cycles, wait out start-up, then the scenarios
    initial begin
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        hold(300);
        t_boot;
        t_flags;
        t_core;
        t_warn;
        t_sd;
        t_pins;
        t_swrst;
        end_of_test;
    end
    // a hang costs a mismatch; the run needs under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        failures++;
        end_of_test;
    end
endmodule // pmrc_reset_config_int_top_tb
